// [design/tap_timer.sv]
// five-channel timer block, one-shot and pwm modes, with an apb register slave
// assumes pins and sub-clock tick are synchronous to pclk; neighbour events come from outside
// Overview of operation
// R01: one-shot decrements; at zero reloads from reload register then stops until trigger
// R02: one-shot trigger while counting reloads and restarts the interval
// R03: one-shot interval is n count clocks; zero leaves the counter idle
// R04: one-shot starts only with start flag set and a trigger
// R05: neighbour trigger is b2 underflow or wrapped lower/upper channel event
// R06: one-shot interrupt request when counter reaches zero
// R07: counter reads return an undefined value in these modes
// R08: one-shot write loads both until first count clock, else reload only
// R09: pulse output low when idle, high while counting
// R10: inverted polarity drives output high while start flag is zero
// R11: mode bits 10 select one-shot, 11 select pwm
// R12: mode bit 2 chooses port pin or pulse output
// R13: edge select bit: 0 falling, 1 rising input edge
// R14: trigger source bit 1 uses routing, 0 soft trigger or start write
// R15: width bit selects 16-bit or 8-bit pwm; keep 0 in one-shot
// R16: clock source field picks undivided, div8, div32 or sub-clock div32; code uses the sub-clock tick undivided
// R17: pwm reloads at each rising pulse edge and counts continuously
// R18: 16-bit pwm high for n clocks, period 2^16-1 clocks
// R19: 8-bit pwm prescale m+1, width n*(m+1), period 255*(m+1)
// R20: pwm starts on start flag or flag plus trigger; clearing flag stops
// R21: pwm interrupt request on each falling pulse edge
// R22: pwm write while counting loads reload only, else both
// R23: start flags share one register, one bit per channel
// R24: pwm ignores triggers once counting has begun
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tap_timer
  import tap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire tap_pkg::tap_apb_req_type apb_req,
  output tap_pkg::tap_apb_rsp_type apb_rsp,
  input wire tap_pkg::tap_ext_in_type ext_in,
  output logic [tap_pkg::NCH-1:0] timer_output_pin,
  output logic [tap_pkg::NCH-1:0] timer_output_en,
  output logic [tap_pkg::NCH-1:0] irq_req
);
  import tap_pkg::*;

  typedef struct packed {
    tap_mode_type [NCH-1:0] mode;
    logic [NCH-1:0] start;
    logic [NCH-1:0] running;
    logic [NCH-1:0] first_seen;
    logic [NCH-1:0] pin_last;
    logic [NCH-1:0] polarity_inv;
    logic [NCH-1:0] out_lvl;
    logic [NCH-1:0] pwm_high;
    logic [NCH-1:0] irq;
    logic [NCH-1:0][1:0] route;
    logic [NCH-1:0][15:0] reload;
    logic [NCH-1:0][15:0] count;
    logic [NCH-1:0][15:0] period;
    logic [NCH-1:0][7:0] presc;
    logic [4:0] div_cnt;
    logic [2:0] ch_sel;
    tap_apb_rsp_type rsp;
  } tap_state_type;

  tap_state_type st_q;
  tap_state_type st_d;

  logic wr_en;
  logic rd_en;
  logic [11:0] idx;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] trig;

  assign idx = apb_req.paddr[13:2];
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && !st_q.rsp.pready;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite && !st_q.rsp.pready;

  // per channel count clock and trigger decode
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    localparam int LO = (i == 0) ? NCH - 1 : i - 1; // R05
    localparam int HI = (i == NCH - 1) ? 0 : i + 1; // R05
    logic edge_hit;
    always_comb
    begin
      unique case (st_q.mode[i].clk_source) // R16
        2'h0: tick[i] = 1'b1;
        2'h1: tick[i] = (st_q.div_cnt[2:0] == DIV8_LAST[2:0]);
        2'h2: tick[i] = (st_q.div_cnt == DIV32_LAST);
        2'h3: tick[i] = ext_in.subclk_tick;
      endcase
      edge_hit = st_q.mode[i].trigger_edge_select ? // R13
        (ext_in.timer_input_pin[i] && !st_q.pin_last[i]) :
        (!ext_in.timer_input_pin[i] && st_q.pin_last[i]);
      unique case (st_q.route[i]) // R05
        2'h0: trig[i] = edge_hit;
        2'h1: trig[i] = ext_in.b2_underflow;
        2'h2: trig[i] = ext_in.neighbour_event[LO];
        2'h3: trig[i] = ext_in.neighbour_event[HI];
      endcase
    end
  end

  always_comb
  begin
    logic [NCH-1:0] soft_trig;
    logic [NCH-1:0] start_set;
    logic go;
    st_d = st_q;
    soft_trig = '0;
    start_set = '0;
    go = 1'b0;
    st_d.div_cnt = st_q.div_cnt + 5'h01;
    st_d.pin_last = ext_in.timer_input_pin;
    st_d.irq = '0;
    st_d.rsp.pready = 1'b0;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata = '0;

    // apb slave: one wait state, answer in the cycle after the access phase starts
    if (apb_req.psel && apb_req.penable && !st_q.rsp.pready)
    begin
      st_d.rsp.pready = 1'b1;
      unique case (idx)
        START_IDX:
        begin
          if (wr_en)
          begin
            st_d.start = apb_req.pwdata[NCH-1:0]; // R23
            start_set = apb_req.pwdata[NCH-1:0] & ~st_q.start;
          end
          st_d.rsp.prdata = {27'h0, st_q.start};
        end
        MODE0_IDX, MODE1_IDX, MODE2_IDX, MODE3_IDX, MODE4_IDX:
        begin
          if (wr_en)
            st_d.mode[3'(idx - MODE0_IDX)] = apb_req.pwdata[7:0];
          st_d.rsp.prdata = {24'h0, st_q.mode[3'(idx - MODE0_IDX)]};
        end
        RELOAD_IDX:
        begin
          // selects channel by bits 18:16, value in 15:0
          if (wr_en)
            st_d.ch_sel = apb_req.pwdata[18:16];
          st_d.rsp.prdata = UNDEF_READ; // R07
        end
        TRIG_IDX:
        begin
          if (wr_en)
          begin
            soft_trig = apb_req.pwdata[NCH-1:0];
            st_d.polarity_inv = apb_req.pwdata[NCH+7:8];
          end
          st_d.rsp.prdata = {16'h0, 3'h0, st_q.polarity_inv, 8'h0};
        end
        ROUTE_IDX:
        begin
          if (wr_en)
            st_d.route = apb_req.pwdata[2*NCH-1:0];
          st_d.rsp.prdata = {22'h0, st_q.route};
        end
        STAT_IDX:
          st_d.rsp.prdata = {19'h0, st_q.pwm_high, 3'h0, st_q.running};
        default:
          st_d.rsp.pslverr = 1'b1;
      endcase
    end

    for (int i = 0; i < NCH; i++)
    begin
      // counter/reload write
      if (wr_en && idx == RELOAD_IDX && apb_req.pwdata[18:16] == 3'(i))
      begin
        st_d.reload[i] = apb_req.pwdata[15:0];
        // the grace window before the first count clock exists in one-shot mode only
        if (!st_q.running[i] ||
            (!st_q.first_seen[i] && st_q.mode[i].op_mode == MODE_ONESHOT))
          st_d.count[i] = apb_req.pwdata[15:0]; // R08 R22
      end
      if (st_q.mode[i].op_mode == MODE_ONESHOT) // R11
      begin
        go = st_q.start[i] && (st_q.mode[i].trigger_source_select ?
          trig[i] : soft_trig[i]); // R04 R14
        if (go && st_q.reload[i] != COUNT_RESET) // R03
        begin
          st_d.running[i] = 1'b1;
          st_d.first_seen[i] = 1'b0;
          st_d.count[i] = st_q.reload[i]; // R02
        end
        else if (st_q.running[i] && tick[i])
        begin
          st_d.first_seen[i] = 1'b1;
          if (st_q.count[i] == 16'h0001)
          begin
            st_d.count[i] = st_q.reload[i]; // R01
            st_d.running[i] = 1'b0;
            st_d.irq[i] = 1'b1; // R06
          end
          else
            st_d.count[i] = st_q.count[i] - 16'h0001; // R01
        end
        st_d.pwm_high[i] = 1'b0;
      end
      else if (st_q.mode[i].op_mode == MODE_PWM)
      begin
        go = st_q.mode[i].trigger_source_select ?
          (st_q.start[i] && trig[i]) : start_set[i]; // R20 R14
        if (!st_q.running[i] && go)
        begin
          st_d.running[i] = 1'b1;
          st_d.first_seen[i] = 1'b0;
          st_d.pwm_high[i] = 1'b1;
          st_d.count[i] = st_q.reload[i]; // R17
          st_d.presc[i] = 8'h00;
          st_d.period[i] = st_q.mode[i].pwm_width_select ?
            {8'h0, PWM8_PERIOD} : PWM16_PERIOD; // R18 R19
        end
        else if (st_q.running[i] && tick[i]) // R24
        begin
          st_d.first_seen[i] = 1'b1;
          if (st_q.mode[i].pwm_width_select && st_q.presc[i] != st_q.reload[i][7:0])
            st_d.presc[i] = st_q.presc[i] + 8'h01; // R19
          else
          begin
            st_d.presc[i] = 8'h00;
            if (st_q.period[i] == 16'h0001)
            begin
              st_d.period[i] = st_q.mode[i].pwm_width_select ?
                {8'h0, PWM8_PERIOD} : PWM16_PERIOD;
              st_d.count[i] = st_q.reload[i]; // R17
              st_d.pwm_high[i] = 1'b1;
            end
            else
              st_d.period[i] = st_q.period[i] - 16'h0001;
            if (st_q.pwm_high[i] && st_q.period[i] != 16'h0001)
            begin
              if ((st_q.mode[i].pwm_width_select ? {8'h0, st_q.count[i][15:8]} :
                   st_q.count[i]) <= 16'h0001)
              begin
                st_d.pwm_high[i] = 1'b0;
                st_d.irq[i] = 1'b1; // R21
              end
              else if (st_q.mode[i].pwm_width_select)
                st_d.count[i][15:8] = st_q.count[i][15:8] - 8'h01; // R19
              else
                st_d.count[i] = st_q.count[i] - 16'h0001; // R18
            end
          end
        end
      end
      else
      begin
        st_d.running[i] = 1'b0;
        st_d.pwm_high[i] = 1'b0;
      end
      if (!st_d.start[i])
      begin
        st_d.running[i] = 1'b0; // R20
        st_d.pwm_high[i] = 1'b0;
      end
      if (st_q.mode[i].op_mode == MODE_PWM && st_q.pwm_high[i] && !st_d.pwm_high[i]
          && !st_d.start[i])
        st_d.irq[i] = st_q.running[i]; // R21
      st_d.out_lvl[i] = (!st_d.start[i] && st_q.polarity_inv[i]) ? 1'b1 : // R10
        (st_q.mode[i].op_mode == MODE_PWM ? st_d.pwm_high[i] : st_d.running[i]); // R09
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign apb_rsp = st_q.rsp;
  assign timer_output_pin = st_q.out_lvl;
  assign irq_req = st_q.irq;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      timer_output_en[i] = st_q.mode[i].pulse_out_select; // R12
  end

  chk_start_stop: assert property (@(posedge pclk) disable iff (!presetn) // R20
    !st_q.start[0] |-> !st_q.running[0])
    else $error("channel runs with start flag clear");
  chk_oneshot_end: assert property (@(posedge pclk) disable iff (!presetn) // R06
    irq_req[0] && st_q.mode[0].op_mode == MODE_ONESHOT |-> !st_q.running[0])
    else $error("one-shot interrupt without stop");
  chk_oneshot_out: assert property (@(posedge pclk) disable iff (!presetn) // R09
    st_q.mode[0].op_mode == MODE_ONESHOT && st_q.start[0] |->
    timer_output_pin[0] == st_q.running[0])
    else $error("one-shot output mismatch");
  chk_inv_high: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !st_q.start[1] && st_q.polarity_inv[1] |-> timer_output_pin[1])
    else $error("inverted idle level not high");
  chk_read_undef: assert property (@(posedge pclk) disable iff (!presetn) // R07
    $rose(apb_rsp.pready) && $past(idx) == RELOAD_IDX |-> apb_rsp.prdata == UNDEF_READ)
    else $error("counter read not masked");
  chk_pwm_irq: assert property (@(posedge pclk) disable iff (!presetn) // R21
    st_q.mode[0].op_mode == MODE_PWM && $fell(st_q.pwm_high[0]) && $past(st_q.start[0])
    && st_q.start[0] |-> irq_req[0])
    else $error("pwm falling edge without interrupt");
  chk_zero_idle: assert property (@(posedge pclk) disable iff (!presetn) // R03
    st_q.mode[0].op_mode == MODE_ONESHOT && st_q.reload[0] == COUNT_RESET
    && !st_q.running[0] |=> !st_q.running[0])
    else $error("zero count started");
  chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // apb slave: pready is a single-cycle pulse
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held over two cycles");
  // channel 0 carries the deeper checks; the other channels share the same generate logic
  chk_oneshot_reload: assert property (@(posedge pclk) disable iff (!presetn) // R01
    st_q.mode[0].op_mode == MODE_ONESHOT && irq_req[0] && $stable(st_q.reload[0])
    |-> st_q.count[0] == st_q.reload[0])
    else $error("one-shot end without reload");
  chk_trig_gate: assert property (@(posedge pclk) disable iff (!presetn) // R04
    st_q.mode[0].op_mode == MODE_ONESHOT && !st_q.running[0] && !st_q.start[0]
    |=> !st_q.running[0])
    else $error("one-shot started without start flag");
  chk_neighbour_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R05
    st_q.route[0] == 2'h2 |-> trig[0] == ext_in.neighbour_event[NCH-1])
    else $error("lower neighbour of channel 0 not wrapped");
  chk_edge_rise: assert property (@(posedge pclk) disable iff (!presetn) // R13
    st_q.route[0] == 2'h0 && st_q.mode[0].trigger_edge_select
    && ext_in.timer_input_pin[0] && !$past(ext_in.timer_input_pin[0]) |-> trig[0])
    else $error("rising pin edge not taken as trigger");
  chk_pwm_reload: assert property (@(posedge pclk) disable iff (!presetn) // R17
    st_q.mode[0].op_mode == MODE_PWM && $rose(st_q.pwm_high[0])
    |-> st_q.count[0] == $past(st_q.reload[0]))
    else $error("pwm rising edge without reload");
  chk_pwm_hold: assert property (@(posedge pclk) disable iff (!presetn) // R24
    st_q.mode[0].op_mode == MODE_PWM && st_q.running[0] && st_q.first_seen[0]
    |=> st_q.first_seen[0] || !st_q.running[0])
    else $error("pwm restarted by a trigger");
  chk_irq_single: assert property (@(posedge pclk) disable iff (!presetn) // R21
    irq_req[0] |=> !irq_req[0])
    else $error("interrupt request longer than one cycle");
  cov_pwm8: cover property (@(posedge pclk) disable iff (!presetn)
    st_q.mode[0].op_mode == MODE_PWM && st_q.mode[0].pwm_width_select && irq_req[0]);
  cov_oneshot: cover property (@(posedge pclk) disable iff (!presetn)
    st_q.mode[0].op_mode == MODE_ONESHOT && irq_req[0]);
  cov_pwm: cover property (@(posedge pclk) disable iff (!presetn)
    st_q.mode[0].op_mode == MODE_PWM && irq_req[0]);
  cov_restart: cover property (@(posedge pclk) disable iff (!presetn)
    st_q.running[0] ##1 st_q.running[0] && st_q.first_seen[0] ##1 !st_q.first_seen[0]);
endmodule // tap_timer
`default_nettype wire

// [design/tap_pkg.sv]
// package for the timer channel block: register map, field positions, reset values, types
// assumes a 32-bit apb slave port with word-aligned registers
package tap_pkg;
  // printed offsets are not all multiples of four: index = printed offset, byte address = 4*index
  localparam logic [11:0] START_IDX = 12'h320;
  localparam logic [11:0] MODE0_IDX = 12'h336;
  localparam logic [11:0] MODE1_IDX = 12'h337;
  localparam logic [11:0] MODE4_IDX = 12'h33A;
  localparam logic [11:0] MODE2_IDX = 12'h338;
  localparam logic [11:0] MODE3_IDX = 12'h339;
  localparam logic [11:0] RELOAD_IDX = 12'h340;
  localparam logic [11:0] TRIG_IDX = 12'h341;
  localparam logic [11:0] ROUTE_IDX = 12'h342;
  localparam logic [11:0] SRC_IDX = 12'h343;
  localparam logic [11:0] STAT_IDX = 12'h344;
  localparam int MODE_LO_POS = 0;
  localparam int PULSE_OUT_POS = 2;
  localparam int EDGE_POS = 3;
  localparam int TSRC_POS = 4;
  localparam int WIDTH_POS = 5;
  localparam int CLK_SRC_POS = 6;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [4:0] START_RESET = 5'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PWM16_PERIOD = 16'hFFFF;
  localparam logic [7:0] PWM8_PERIOD = 8'hFF;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [31:0] UNDEF_READ = 32'h0000_0000;
  localparam int NCH = 5;

  typedef struct packed {
    logic [1:0] clk_source;
    logic pwm_width_select;
    logic trigger_source_select;
    logic trigger_edge_select;
    logic pulse_out_select;
    logic [1:0] op_mode;
  } tap_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } tap_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tap_apb_rsp_type;

  typedef struct packed {
    logic [NCH-1:0] timer_input_pin;
    logic [NCH-1:0] neighbour_event;
    logic b2_underflow;
    logic subclk_tick;
  } tap_ext_in_type;
endpackage

// [verification/tap_far_side.sv]
// far-side model for tap_timer: trigger sources on the channel inputs and a sub-clock tick
// assumes the bench calls fire() from its main thread; all changes land just after a pclk edge
`timescale 1ns/10ps
`default_nettype none
module tap_far_side
  import tap_pkg::*;
#(
  parameter int SUB_DIV = 12
)
(
  input wire logic pclk,
  output var tap_pkg::tap_ext_in_type ext_in
);
  int sub_q;
  initial ext_in = '0;
  // tick runs free so a channel never knows where in the sub-clock period it starts
  always @(posedge pclk)
  begin
    sub_q <= (sub_q == SUB_DIV - 1) ? 0 : sub_q + 1;
    ext_in.subclk_tick <= (sub_q == 0);
  end
  // kinds: 0 pin rise, 1 pin fall, 2 b2 underflow, 3 channel 4 event, 4 channel 1 event
  task automatic fire(input int kind);
    @(posedge pclk);
    case (kind)
      0: ext_in.timer_input_pin[0] <= 1'b1;
      1: ext_in.timer_input_pin[0] <= 1'b0;
      2: ext_in.b2_underflow <= 1'b1;
      3: ext_in.neighbour_event[4] <= 1'b1;
      default: ext_in.neighbour_event[1] <= 1'b1;
    endcase
    @(posedge pclk);
    ext_in.b2_underflow <= 1'b0;
    ext_in.neighbour_event <= '0;
  endtask
endmodule // tap_far_side
`default_nettype wire

// [verification/tb_tap_timer.sv]
// testbench for tap_timer: apb register tasks and channel 0 one-shot and pwm sequences
// assumes tap_far_side supplies triggers; the pin monitor measures widths in pclk cycles
`timescale 1ns/10ps
`default_nettype none
module tb_tap_timer;
  import tap_pkg::*;
  localparam int SUB = 12;
  logic pclk;
  logic presetn;
  tap_apb_req_type req;
  tap_apb_rsp_type rsp;
  tap_ext_in_type ext_in;
  logic [NCH-1:0] pin;
  logic [NCH-1:0] pin_en;
  logic [NCH-1:0] irq;
  int bad_count, samples_checked, cyc, run, hi_len, per_len, rise_at, rises, falls, irq_cnt;
  int t_done;
  logic prev = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [11:0] mode_idx [5] = '{MODE0_IDX, MODE1_IDX, MODE2_IDX, MODE3_IDX, MODE4_IDX};
  // edge, route, kind, expected width
  int cs [8][4] = '{'{1, 0, 0, 5}, '{1, 0, 1, 0}, '{0, 0, 0, 0}, '{0, 0, 1, 5},
    '{1, 1, 2, 5}, '{1, 2, 4, 0}, '{1, 2, 3, 5}, '{1, 3, 4, 5}};
  tap_timer tap_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_in(ext_in), .timer_output_pin(pin), .timer_output_en(pin_en), .irq_req(irq));
  tap_far_side #(.SUB_DIV(SUB)) tap_far_side_i (.pclk(pclk), .ext_in(ext_in));
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // pin 0 monitor; also cuts a hang short
  always @(posedge pclk)
  begin
    cyc++;
    if (pin[0] === 1'b1)
    begin
      if (!prev)
      begin
        per_len = cyc - rise_at;
        rise_at = cyc;
        rises++;
      end
      run++;
    end
    else if (prev)
    begin
      hi_len = run;
      run = 0;
      falls++;
    end
    prev = (pin[0] === 1'b1);
    if (irq[0] === 1'b1)
      irq_cnt++;
    if (cyc == 90000)
    begin
      bad_count++;
      close_out();
    end
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic xfer(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20)
      bad_count++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    t_done = cyc;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d);
  endtask
  task automatic rdchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0);
    check(name, exp, rd);
  endtask
  task automatic wait_hi(input int max);
    int k;
    k = 0;
    while (hi_len == 0 && k < max)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic wait_rise(input int target, input int max);
    int k;
    k = 0;
    while (rises < target && k < max)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  // soft trigger of channel 0, then the measured width, irq and idle state
  task automatic oneshot(input int n);
    hi_len = 0;
    irq_cnt = 0;
    wr(TRIG_IDX, 32'h1);
    wait_hi(200);
    check("oneshot width", 32'(n), 32'(hi_len));
    xfer(STAT_IDX, 1'b0, 32'h0);
    check("oneshot stopped", 32'h0, 32'(rd[0]));
    check("oneshot irq", 32'h1, 32'(irq_cnt));
  endtask
  initial
  begin
    int t1, d, r0;
    presetn = 1'b0;
    req = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdchk("mode reset", mode_idx[i], 32'(MODE_RESET));
    rdchk("start reset", START_IDX, 32'(START_RESET));
    wr(START_IDX, 32'h1F);
    rdchk("start flags", START_IDX, 32'h1F);
    wr(START_IDX, 32'h0);
    xfer(12'h345, 1'b0, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    wr(MODE0_IDX, 32'h06);
    wr(RELOAD_IDX, 32'h5);
    wr(START_IDX, 32'h1);
    @(negedge pclk);
    check("idle pin", 32'h0, 32'(pin[0]));
    check("output role", 32'h1, 32'(pin_en[0]));
    rdchk("counter read", RELOAD_IDX, UNDEF_READ);
    oneshot(5);
    oneshot(5);
    wr(RELOAD_IDX, 32'h14);
    hi_len = 0;
    wr(TRIG_IDX, 32'h1);
    t1 = t_done;
    repeat (6) @(posedge pclk);
    wr(TRIG_IDX, 32'h1);
    wait_hi(100);
    check("retrigger width", 32'(t_done - t1 + 20), 32'(hi_len));
    hi_len = 0;
    wr(TRIG_IDX, 32'h1);
    wr(RELOAD_IDX, 32'h7);
    wait_hi(100);
    check("late write width", 32'h14, 32'(hi_len));
    oneshot(7);
    wr(RELOAD_IDX, 32'h0);
    hi_len = 0;
    wr(TRIG_IDX, 32'h1);
    wait_hi(30);
    check("zero count", 32'h0, 32'(hi_len));
    wr(RELOAD_IDX, 32'h5);
    wr(START_IDX, 32'h0);
    wr(TRIG_IDX, 32'h101);
    wait_hi(30);
    check("no start flag", 32'h0, 32'(hi_len));
    @(negedge pclk);
    check("inverted idle", 32'h1, 32'(pin[0]));
    rdchk("invert readback", TRIG_IDX, 32'h100);
    wr(TRIG_IDX, 32'h0);
    wr(START_IDX, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(MODE0_IDX, 32'h16 | (32'(cs[i][0]) << EDGE_POS));
      wr(ROUTE_IDX, 32'(cs[i][1]));
      hi_len = 0;
      tap_far_side_i.fire(cs[i][2]);
      wait_hi(40);
      check("trigger source", 32'(cs[i][3]), 32'(hi_len));
    end
    wr(ROUTE_IDX, 32'h0);
    wr(RELOAD_IDX, 32'h2);
    for (int c = 1; c < 4; c++)
    begin
      d = (c == 1) ? 8 : (c == 2) ? 32 : SUB;
      wr(MODE0_IDX, 32'h06 | (32'(c) << CLK_SRC_POS));
      hi_len = 0;
      wr(TRIG_IDX, 32'h1);
      wait_hi(200);
      check_rng("divided width", d + 1, 2 * d, hi_len);
    end
    wr(START_IDX, 32'h0);
    wr(MODE0_IDX, 32'h37);
    wr(ROUTE_IDX, 32'h1);
    wr(RELOAD_IDX, 32'h0402);
    wr(START_IDX, 32'h1);
    r0 = rises;
    repeat (20) @(posedge pclk);
    check("pwm waits trigger", 32'(r0), 32'(rises));
    irq_cnt = 0;
    falls = 0;
    tap_far_side_i.fire(2);
    wait_rise(r0 + 1, 100);
    repeat (100) @(posedge pclk);
    tap_far_side_i.fire(2);
    wait_rise(r0 + 2, 2000);
    check("pwm8 width", 32'hC, 32'(hi_len));
    check("pwm8 period", 32'h2FD, 32'(per_len));
    wr(RELOAD_IDX, 32'h0602);
    wait_rise(r0 + 3, 2000);
    check("pwm8 old width", 32'hC, 32'(hi_len));
    wait_rise(r0 + 4, 2000);
    check("pwm8 new width", 32'h12, 32'(hi_len));
    check("pwm irq count", 32'(falls), 32'(irq_cnt));
    wr(START_IDX, 32'h0);
    r0 = rises;
    repeat (800) @(posedge pclk);
    check("pwm stopped", 32'(r0), 32'(rises));
    wr(MODE0_IDX, 32'h07);
    wr(RELOAD_IDX, 32'h3);
    wr(START_IDX, 32'h1);
    wait_rise(r0 + 2, 70000);
    check("pwm16 width", 32'h3, 32'(hi_len));
    check("pwm16 period", 32'hFFFF, 32'(per_len));
    close_out();
  end
endmodule // tb_tap_timer
`default_nettype wire
